// File: charger_timer_config_nvm_ctrl.sv
// Charger timer settings, write unlock and nonvolatile program control
//
// How it works
// R1: Every bit of the timer settings register reads and writes.
// R2: Charging ends at termination voltage with current under the end threshold.
// R3: Thermistor select bit chooses 10 kilohm or 100 kilohm.
// R4: Top-off code steps 20 minutes; code 7 disables it.
// R5: Top-off timer starts at termination voltage with current below end-of-charge.
// R6: Full-charge code 0 disables; codes 1-7 give 200-1400 minutes.
// R7: Full-charge timer starts when battery rises above 3.0 V.
// R8: Settings registers 02-06 are reachable only while unlocked.
// R9: Unlock register resets to zero; only bit 0 writable.
// R10: Writing 1 to program bit copies settings to nonvolatile memory.
// R11: Program-control register resets to zero; only bit 0 writable.
// R12: Host keeps input supply and enable present 200 ms while programming.
// R13: An expired enabled timer stops charging and drives the fault low.
`include "charger_consts.svh"
`timescale 1ns/100ps
module charger_timer_config_nvm_ctrl
  import charger_pkg::*;
#(
  parameter logic [32:0] MINUTE_CYCLES   = `MINUTE_CYCLES,
  parameter int unsigned NVM_HOLD_CYCLES = `NVM_HOLD_CYCLES
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [7:0]    reg_addr,
  input  wire charger_pkg::byte_t reg_wdata,
  output logic [7:0]         reg_rdata,
  output logic               reg_ack,
  output logic               reg_refused,
  input  wire logic          vbat_at_term,
  input  wire logic          vbat_above_3v0,
  input  wire logic          ibat_below_topoff_end,
  input  wire logic          ibat_below_eoc,
  input  wire logic          input_supply,
  input  wire logic          enable_in,
  input  wire logic          nvm_ready,
  output logic               nvm_write,
  output logic [39:0]        nvm_data,
  output logic               nvm_error,
  output logic               charge_enable,
  output logic               topoff_end_high,
  output logic               thermistor_select,
  output logic               fault_out_n_o,
  output logic               fault_out_n_oe
);
  import charger_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic is_cfg_addr(input logic [7:0] a);
    return (a >= `CFG_FIRST_ADDR) && (a <= `CFG_LAST_ADDR);
  endfunction

  function automatic logic [31:0] topoff_minutes(input timeout_code_t c);
    return 32'(c) * 32'(`TOPOFF_STEP_MIN);
  endfunction

  function automatic logic [31:0] full_minutes(input timeout_code_t c);
    return 32'(c) * 32'(`FULL_STEP_MIN);
  endfunction

  // Control registers read back their single live bit
  function automatic byte_t ctrl_read(input logic b);
    return {7'h00, b};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    byte_t [4:0]  cfg;
    logic         unlock;
    logic         nvm_program_request;
    nvm_state_t   nvm_state;
    logic [31:0]  hold_cnt;
    logic [32:0]  minute_cnt;
    logic         minute_tick;
    logic         charging_done;
    logic         timeout_fault;
    logic [7:0]   rdata;
    logic         ack;
    logic         refused;
    logic         nvm_write;
    logic         nvm_error;
  } state_t;

  state_t s, next_s;
  timer_if topoff_if ();
  timer_if full_if ();

  byte_t         timer_settings_register;
  timeout_code_t topoff_timeout;
  timeout_code_t full_charge_timeout;
  logic [2:0]    cfg_idx;
  logic          cfg_hit;
  logic          unlock_hit;
  logic          nvm_hit;

  assign timer_settings_register = s.cfg[4];
  assign topoff_timeout          = timer_settings_register[`TOPOFF_TO_LSB +: 3];
  assign full_charge_timeout     = timer_settings_register[`FULL_TO_LSB +: 3];
  assign cfg_idx                 = 3'(reg_addr - `CFG_FIRST_ADDR);
  assign cfg_hit                 = is_cfg_addr(reg_addr);
  assign unlock_hit              = (reg_addr == `WRITE_UNLOCK_ADDR);
  assign nvm_hit                 = (reg_addr == `NVM_CTRL_ADDR);

  assign topoff_if.minute_tick = s.minute_tick;
  // Device enable low also rearms an expired timer
  assign topoff_if.enable      = (topoff_timeout != 3'h7) && enable_in; // R4
  assign topoff_if.limit_min   = topoff_minutes(topoff_timeout); // R4
  assign topoff_if.start       = vbat_at_term && ibat_below_eoc; // R5
  assign full_if.minute_tick   = s.minute_tick;
  assign full_if.enable        = (full_charge_timeout != 3'h0) && enable_in; // R6
  assign full_if.limit_min     = full_minutes(full_charge_timeout); // R6
  assign full_if.start         = vbat_above_3v0; // R7

  safety_timer u_topoff (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .t        (topoff_if.tmr)
  );

  safety_timer u_full (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .t        (full_if.tmr)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.ack     = 1'b0;
    next_s.refused = 1'b0;
    next_s.rdata   = s.rdata;
    // Minute prescaler
    next_s.minute_tick = 1'b0;
    if (s.minute_cnt >= MINUTE_CYCLES - 33'h1) begin
      next_s.minute_cnt  = 33'h0;
      next_s.minute_tick = 1'b1;
    end else begin
      next_s.minute_cnt = s.minute_cnt + 33'h1;
    end
    // Register access
    if (reg_wr || reg_rd) begin
      next_s.ack = 1'b1;
      if (cfg_hit && !s.unlock) begin
        next_s.refused = 1'b1; // R8
        next_s.rdata   = 8'h00;
      end else if (reg_wr) begin
        if (cfg_hit) begin
          next_s.cfg[cfg_idx] = reg_wdata; // R1
        end else if (unlock_hit) begin
          next_s.unlock = reg_wdata[0]; // R9
        end else if (nvm_hit) begin
          if (reg_wdata[0] && s.nvm_state == NVM_IDLE) begin
            next_s.nvm_program_request = 1'b1; // R11
          end else if (!reg_wdata[0]) begin
            next_s.nvm_program_request = 1'b0;
          end
        end else begin
          next_s.refused = 1'b1; // R8
          next_s.rdata   = 8'h00;
        end
      end else begin
        if (cfg_hit) begin
          next_s.rdata = s.cfg[cfg_idx]; // R1
        end else if (unlock_hit) begin
          next_s.rdata = ctrl_read(s.unlock); // R9
        end else if (nvm_hit) begin
          next_s.rdata = ctrl_read(s.nvm_program_request); // R11
        end else begin
          next_s.rdata   = 8'h00;
          next_s.refused = 1'b1;
        end
      end
    end
    // Nonvolatile programming sequence
    next_s.nvm_write = 1'b0;
    unique case (s.nvm_state)
      NVM_IDLE: begin
        next_s.hold_cnt = 32'h0;
        if (s.nvm_program_request) begin
          next_s.nvm_state = NVM_WRITE; // R10
          next_s.nvm_error = 1'b0;
        end
      end
      NVM_WRITE: begin
        next_s.nvm_write = 1'b1; // R10
        if (!input_supply || !enable_in) begin
          next_s.nvm_error = 1'b1; // R12
          next_s.nvm_state = NVM_DONE;
        end else if (s.hold_cnt >= NVM_HOLD_CYCLES - 1 && nvm_ready) begin
          next_s.nvm_state = NVM_DONE; // R12
        end else if (s.hold_cnt < NVM_HOLD_CYCLES - 1) begin
          next_s.hold_cnt = s.hold_cnt + 32'h1;
        end
      end
      NVM_DONE: begin
        next_s.nvm_program_request = 1'b0;
        next_s.nvm_state           = NVM_IDLE;
      end
    endcase
    // End of charge and timeouts
    if (vbat_at_term && ibat_below_topoff_end) begin
      next_s.charging_done = 1'b1; // R2
    end else if (!vbat_at_term) begin
      next_s.charging_done = 1'b0;
    end
    if (topoff_if.expired || full_if.expired) begin
      next_s.timeout_fault = 1'b1; // R13
    end else if (!enable_in) begin
      next_s.timeout_fault = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '{
        cfg:                 {`CFG_RESET_VALUE, 32'h0000_0000},
        unlock:              1'(`UNLOCK_RESET_VALUE), // R9
        nvm_program_request: 1'(`NVM_CTRL_RESET), // R11
        nvm_state:           NVM_IDLE,
        hold_cnt:            32'h0,
        minute_cnt:          33'h0,
        minute_tick:         1'b0,
        charging_done:       1'b0,
        timeout_fault:       1'b0,
        rdata:               8'h00,
        ack:                 1'b0,
        refused:             1'b0,
        nvm_write:           1'b0,
        nvm_error:           1'b0
      };
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic timer_bit_d;
  logic therm_d;
  logic end_d;
  logic charge_d;
  logic fault_d;
  assign end_d    = s.cfg[4][`TOPOFF_END_BIT]; // R2
  assign therm_d  = s.cfg[4][`THERM_SEL_BIT]; // R3
  assign charge_d = !s.charging_done && !s.timeout_fault; // R13
  assign fault_d  = s.timeout_fault; // R13
  assign timer_bit_d = 1'b0;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      topoff_end_high   <= 1'b0;
      thermistor_select <= 1'b0;
      charge_enable     <= 1'b0;
      fault_out_n_oe    <= 1'b0;
    end else begin
      topoff_end_high   <= end_d;
      thermistor_select <= therm_d;
      charge_enable     <= charge_d;
      fault_out_n_oe    <= fault_d;
    end
  end

  always_ff @(posedge core_clk) begin
    fault_out_n_o <= timer_bit_d;
  end

  assign reg_rdata   = s.rdata;
  assign reg_ack     = s.ack;
  assign reg_refused = s.refused;
  assign nvm_write   = s.nvm_write;
  assign nvm_error   = s.nvm_error;
  assign nvm_data    = {s.cfg[4], s.cfg[3], s.cfg[2], s.cfg[1], s.cfg[0]};
endmodule // charger_timer_config_nvm_ctrl

// File: charger_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CHARGER_CONSTS_SVH
`define CHARGER_CONSTS_SVH
`define CFG_FIRST_ADDR      8'h02
`define CFG_LAST_ADDR       8'h06
`define TIMER_SETTINGS_ADDR 8'h06
`define WRITE_UNLOCK_ADDR   8'h11
`define NVM_CTRL_ADDR       8'h12
`define TOPOFF_END_BIT      7
`define THERM_SEL_BIT       6
`define TOPOFF_TO_LSB       3
`define FULL_TO_LSB         0
`define CFG_RESET_VALUE     8'h00
`define UNLOCK_RESET_VALUE  8'h00
`define NVM_CTRL_RESET      8'h00
`define TOPOFF_STEP_MIN     20
`define FULL_STEP_MIN       200
`define CLK_HZ              100000000
`define SECONDS_PER_MIN     60
`define MINUTE_CYCLES       (33'(`CLK_HZ) * 33'(`SECONDS_PER_MIN))
`define NVM_HOLD_MS         200
`define NVM_HOLD_CYCLES     ((`CLK_HZ / 1000) * `NVM_HOLD_MS)
`endif

// File: charger_pkg.sv
// Types shared by the charger configuration block
package charger_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] timeout_code_t;
  typedef enum logic [2:0] {
    NVM_IDLE  = 3'b001,
    NVM_WRITE = 3'b010,
    NVM_DONE  = 3'b100
  } nvm_state_t;
  typedef enum logic [2:0] {
    TMR_IDLE    = 3'b001,
    TMR_RUN     = 3'b010,
    TMR_EXPIRED = 3'b100
  } tmr_state_t;
endpackage

// File: timer_if.sv
// Links between the register bank and its two safety timers
`timescale 1ns/100ps
interface timer_if;
  logic        start;
  logic        enable;
  logic [31:0] limit_min;
  logic        minute_tick;
  logic        expired;
  modport ctrl (output start, output enable, output limit_min, output minute_tick,
                input expired);
  modport tmr (input start, input enable, input limit_min, input minute_tick,
               output expired);
endinterface

// File: safety_timer.sv
// Minute-resolution safety timer with expiry flag
`timescale 1ns/100ps
module safety_timer
  import charger_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  timer_if.tmr     t
);
  typedef struct packed {
    tmr_state_t  state;
    logic [31:0] minutes;
  } tstate_t;
  tstate_t s, next_s;
  always_comb begin
    next_s = s;
    unique case (s.state)
      TMR_IDLE: begin
        next_s.minutes = 32'h0;
        if (t.enable && t.start) begin
          next_s.state = TMR_RUN;
        end
      end
      TMR_RUN: begin
        if (!t.enable || !t.start) begin
          next_s.state = TMR_IDLE;
        end else if (s.minutes >= t.limit_min) begin
          next_s.state = TMR_EXPIRED;
        end else if (t.minute_tick) begin
          next_s.minutes = s.minutes + 32'h1;
        end
      end
      TMR_EXPIRED: begin
        if (!t.enable) begin
          next_s.state = TMR_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '{state: TMR_IDLE, minutes: 32'h0};
    end else begin
      s <= next_s;
    end
  end
  assign t.expired = (s.state == TMR_EXPIRED);
endmodule // safety_timer

// File: charger_monitor.sv
// Assertion checker for the charger register bank
`timescale 1ns/100ps
module charger_monitor #(
  parameter logic [32:0] MINUTE_CYCLES   = 33'h0_0000_000a,
  parameter int unsigned NVM_HOLD_CYCLES = 20
) (
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_addr,
  input wire charger_pkg::byte_t reg_wdata,
  input wire logic [7:0]         reg_rdata,
  input wire logic               reg_ack,
  input wire logic               reg_refused,
  input wire logic               nvm_write,
  input wire logic [39:0]        nvm_data,
  input wire logic               nvm_error,
  input wire logic               charge_enable,
  input wire logic               topoff_end_high,
  input wire logic               thermistor_select,
  input wire logic               fault_out_n_oe
);
  import charger_pkg::*;
  logic        req;
  logic        mapped;
  logic [31:0] hold_cnt;
  assign req = reg_wr | reg_rd;
  assign mapped = reg_addr inside {[8'h02:8'h06], 8'h11, 8'h12};
  ////////////////////////////////////////////////////////////////
  // Cycles spent programming
  always_ff @(posedge core_clk) begin
    if (!rst_n || !nvm_write) begin
      hold_cnt <= 32'h0;
    end else begin
      hold_cnt <= hold_cnt + 32'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_set_wr;
    reg_wr && reg_addr == 8'h06 ##1 reg_ack && !reg_refused;
  endsequence
  sequence s_prog_req;
    reg_wr && reg_addr == 8'h12 && reg_wdata[0] && !nvm_write;
  endsequence
  ////////////////////////////////////////////////////////////////
  a_ack_follows_req: assert property (req |=> reg_ack)
    else $error("no ack after request");
  a_ack_has_cause: assert property (reg_ack |-> $past(req))
    else $error("ack without request");
  a_unmapped_refused: assert property (req && !mapped |=> reg_refused && reg_rdata == 8'h00)
    else $error("unmapped access not refused");
  a_upper_bits_zero: assert property (reg_rd && !reg_wr && reg_addr inside {8'h11, 8'h12}
    |=> reg_rdata[7:1] == 7'h00) else $error("upper control bits not zero");
  a_settings_stored: assert property (s_set_wr |-> nvm_data[39:32] == $past(reg_wdata))
    else $error("settings write lost");
  a_fields_track: assert property (s_set_wr |=> thermistor_select == nvm_data[38]
    && topoff_end_high == nvm_data[39]) else $error("field outputs stale");
  a_prog_starts: assert property (s_prog_req |-> ##[1:3] nvm_write)
    else $error("programming not started");
  a_prog_hold: assert property ($fell(nvm_write) && !nvm_error |-> hold_cnt >= NVM_HOLD_CYCLES)
    else $error("programming too short");
  a_fault_blocks: assert property (fault_out_n_oe [*2] |-> !charge_enable)
    else $error("charging during fault");
  a_no_fault_disabled: assert property ($rose(fault_out_n_oe) |-> nvm_data[37:32] != 6'h38)
    else $error("fault with both timers off");
  a_reset_clears: assert property (@(posedge core_clk) disable iff (1'b0)
    !rst_n |=> !reg_ack && !nvm_write && !fault_out_n_oe) else $error("reset not clean");
endmodule // charger_monitor
bind charger_timer_config_nvm_ctrl charger_monitor #(
  .MINUTE_CYCLES(MINUTE_CYCLES), .NVM_HOLD_CYCLES(NVM_HOLD_CYCLES)) mon (.*);

// File: nvm_model.sv
// Behavioural nonvolatile memory answering program requests
`timescale 1ns/100ps
module nvm_model #(
  parameter int unsigned WRITE_CYCLES = 30
) (
  input  wire logic        core_clk,
  input  wire logic        nvm_write,
  input  wire logic [39:0] nvm_data,
  output logic             nvm_ready,
  output logic [39:0]      stored
);
  int unsigned cnt = 0;
  initial nvm_ready = 1'b0;
  initial stored = 40'h0;
  always @(posedge core_clk) begin
    cnt <= nvm_write ? cnt + 1 : 0;
    nvm_ready <= nvm_write && cnt >= WRITE_CYCLES;
    if (nvm_write && cnt == WRITE_CYCLES) stored <= nvm_data;
  end
endmodule // nvm_model

// File: charger_timer_config_nvm_ctrl_tb_top.sv
// Self-checking bench for the charger register bank
`timescale 1ns/100ps
module charger_timer_config_nvm_ctrl_tb_top;
  import charger_pkg::*;
  localparam int unsigned MIN_CYC = 10;
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic vbat_at_term = 1'b0, vbat_above_3v0 = 1'b0, ibat_below_eoc = 1'b0;
  logic ibat_below_topoff_end = 1'b0, input_supply = 1'b1, enable_in = 1'b1;
  logic nvm_ready, nvm_write, nvm_error, charge_enable, reg_ack, reg_refused, rf;
  logic topoff_end_high, thermistor_select, fault_out_n_o, fault_out_n_oe;
  logic [7:0]  reg_addr = 8'h00;
  byte_t       reg_wdata = 8'h00;
  byte_t       v;
  logic [7:0]  reg_rdata, q;
  logic [39:0] nvm_data, stored, img;
  logic [31:0] seed = 32'h4e12;
  int          n_fail = 0;
  int          checks_done = 0;
  wire         fault_pin = fault_out_n_oe ? fault_out_n_o : 1'b1;
  always #5 core_clk = ~core_clk;
  charger_timer_config_nvm_ctrl #(
    .MINUTE_CYCLES(33'(MIN_CYC)), .NVM_HOLD_CYCLES(20)) dut (.*);
  nvm_model #(.WRITE_CYCLES(5)) mem (.*);
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Minutes of the armed timer, in clock cycles
  function automatic int unsigned expiry(input byte_t c);
    return (c[2:0] != 3'b000) ? c[2:0] * 200 * MIN_CYC : c[5:3] * 20 * MIN_CYC;
  endfunction
  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input byte_t d);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    chk("ack", reg_ack, 1'b1);
    q = reg_rdata;
    rf = reg_refused;
  endtask
  task automatic run_timer(input byte_t c);
    int unsigned e;
    e = expiry(c);
    acc(1'b1, 8'h06, c);
    @(posedge core_clk);
    vbat_above_3v0 <= 1'b1;
    vbat_at_term <= c[2:0] == 3'b000;
    ibat_below_eoc <= c[2:0] == 3'b000;
    repeat (e * 9 / 10) @(posedge core_clk);
    #1;
    if (e > 0) chk("early", fault_out_n_oe, 1'b0);
    repeat (e / 10 + 20) @(posedge core_clk);
    #1;
    chk("fault_pin", fault_pin, 1'b0);
    chk("charge_off", charge_enable, 1'b0);
    @(posedge core_clk);
    enable_in <= 1'b0;
    {vbat_above_3v0, vbat_at_term, ibat_below_eoc, ibat_below_topoff_end} <= 4'h0;
    repeat (3) @(posedge core_clk);
    enable_in <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    results();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    acc(1'b0, 8'h11, 8'h00);
    chk("unlock_reset", {rf, q}, 9'h000);
    acc(1'b0, 8'h12, 8'h00);
    chk("prog_reset", {rf, q}, 9'h000);
    acc(1'b1, 8'h06, 8'h5a);
    chk("locked_write", rf, 1'b1);
    acc(1'b1, 8'h11, 8'hff);
    acc(1'b0, 8'h11, 8'h00);
    chk("unlock_bits", {rf, q}, 9'h001);
    acc(1'b0, 8'h06, 8'h00);
    chk("refused_kept", {rf, q}, 9'h000);
    acc(1'b0, 8'h2c, 8'h00);
    chk("unmapped", {rf, q}, 9'h100);
    acc(1'b1, 8'h2c, 8'h55);
    chk("unmapped_wr", {rf, q}, 9'h100);
    acc(1'b1, 8'h12, 8'hfe);
    acc(1'b0, 8'h12, 8'h00);
    chk("prog_bits", {rf, q}, 9'h000);
    $display("registers test done");
    for (int k = 0; k < 3; k++) begin
      for (int a = 2; a <= 6; a++) begin
        seed = xs(seed);
        v = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : seed[7:0];
        img = {v, img[39:8]};
        acc(1'b1, a[7:0], v);
      end
      for (int a = 2; a <= 6; a++) begin
        acc(1'b0, a[7:0], 8'h00);
        chk("settings", {rf, q}, {1'b0, img[(a - 2) * 8 +: 8]});
      end
      chk("end_sel", topoff_end_high, img[39]);
      chk("therm_sel", thermistor_select, img[38]);
    end
    acc(1'b1, 8'h12, 8'h01);
    repeat (4) @(posedge core_clk);
    #1;
    chk("prog_busy", nvm_write, 1'b1);
    for (int i = 0; i < 300 && nvm_write !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("prog_done", nvm_write, 1'b0);
    chk("stored", stored, img);
    chk("prog_error", nvm_error, 1'b0);
    acc(1'b0, 8'h12, 8'h00);
    chk("prog_clear", {rf, q}, 9'h000);
    acc(1'b1, 8'h12, 8'h01);
    repeat (5) @(posedge core_clk);
    input_supply <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    chk("prog_abort", {nvm_error, nvm_write}, 2'b10);
    @(posedge core_clk);
    input_supply <= 1'b1;
    chk("charging", charge_enable, 1'b1);
    @(posedge core_clk);
    vbat_at_term <= 1'b1;
    ibat_below_topoff_end <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("charge_end", charge_enable, 1'b0);
    $display("program test done");
    for (int c = 0; c < 7; c++) run_timer({2'b00, c[2:0], 3'b000});
    for (int c = 1; c < 8; c++) run_timer({2'b00, 3'b111, c[2:0]});
    acc(1'b1, 8'h06, 8'h38);
    @(posedge core_clk);
    {vbat_above_3v0, vbat_at_term, ibat_below_eoc} <= 3'h7;
    repeat (3000) @(posedge core_clk);
    #1;
    chk("disabled", fault_out_n_oe, 1'b0);
    acc(1'b1, 8'h11, 8'h00);
    acc(1'b1, 8'h06, 8'h01);
    chk("relocked", rf, 1'b1);
    $display("timer test done");
    results();
  end
endmodule // charger_timer_config_nvm_ctrl_tb_top
